// *** logic/rosl_out_mux.v ***
// Purpose : Per-pin selector from a 4-bit code to one peripheral output
// Assumes : Code 0 means no peripheral
// Notes   : Purely combinational
`timescale 1ns/1ps
`include "rosl_regs.vh"

module rosl_out_mux (
   // Select and sources
   input  wire [3:0]  sel_i,
   input  wire [14:0] periph_out_i,
   // Pin side
   output reg         pin_o,
   output reg         pin_oe_o
);
   always @* begin
      pin_o    = 1'b0;
      pin_oe_o = 1'b0;
      if (sel_i != `ROSL_SEL_NULL) begin
         pin_o    = periph_out_i[sel_i - 4'h1];
         pin_oe_o = 1'b1;
      end
   end
endmodule // rosl_out_mux

// *** logic/rosl_pin_map.v ***
// Purpose : Remappable output select with write lock and unlock sequence
// Assumes : AHB-Lite single word transfers, zero wait states
// Notes   : Lock-once option comes from configuration word three
`timescale 1ns/1ps
`include "rosl_regs.vh"

module rosl_pin_map (
   // Clock and reset
   input  wire        core_clk_i,
   input  wire        rst_n_i,
   // AHB-Lite slave
   input  wire        hsel_i,
   input  wire [11:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire        hready_i,
   input  wire [31:0] hwdata_i,
   output wire [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   // Configuration word three, static strap
   input  wire [31:0] device_config_word_three_i,
   // Peripheral outputs and pins
   input  wire [14:0] periph_out_i,
   output wire [7:0]  pin_o,
   output wire [7:0]  pin_oe_o,
   // Input mapping, selected pin index per peripheral input
   input  wire [7:0]  pin_in_i,
   output wire [7:0]  periph_in_o,
   // Status
   output wire        map_write_lock_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg  [3:0]  out_sel_r [0:7];
   reg  [3:0]  in_sel_r  [0:7];
   reg         map_write_lock_r;
   reg         lock_seen_r;
   reg  [2:0]  key_state_r;
   reg         once_opt_r;
   reg         once_cap_r;
   reg  [31:0] hrdata_r;
   reg  [7:0]  pin_in_s1_r;
   reg  [7:0]  pin_in_s2_r;
   reg         wr_pend_r;
   reg  [11:0] wr_addr_r;
   integer     i;

   // Both keys must be seen in order; key one alone must not arm a change
   localparam KEY_IDLE  = 3'b001;
   localparam KEY_HALF  = 3'b010;
   localparam KEY_ARMED = 3'b100;

   wire        addr_ok  = hsel_i & hready_i & htrans_i[1];
   wire [31:0] cfg_ctrl = {18'h0, map_write_lock_r, 13'h0};

   // Index of a select register, or 4'hf when outside the window
   function [3:0] sel_index;
      input [11:0] a;
      input [11:0] base;
      begin
         if (a[11:8] == base[11:8] && a[7:5] == 3'h0 && a[1:0] == 2'h0)
            sel_index = {1'b0, a[4:2]};
         else
            sel_index = 4'hf;
      end
   endfunction

   wire [3:0] wr_out_idx = sel_index(wr_addr_r, `ROSL_OUT_SEL_BASE);
   wire [3:0] wr_in_idx  = sel_index(wr_addr_r, `ROSL_IN_SEL_BASE);
   wire [3:0] rd_out_idx = sel_index(haddr_i, `ROSL_OUT_SEL_BASE);
   wire [3:0] rd_in_idx  = sel_index(haddr_i, `ROSL_IN_SEL_BASE);

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   // Zero wait states and always OKAY; locked writes still complete
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_r;
   assign map_write_lock_o = map_write_lock_r;

   // ----------------------------------------
   // Strap capture after reset release
   // ----------------------------------------
   // Strap is caught by a clocked process, never loaded by the async reset
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         once_cap_r <= 1'b0;
         once_opt_r <= 1'b1;
      end else if (!once_cap_r) begin
         once_cap_r <= 1'b1;
         once_opt_r <= device_config_word_three_i[`ROSL_CFG3_ONCE_BIT];
      end
   end

   // ----------------------------------------
   // Address phase capture and read data
   // ----------------------------------------
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
         hrdata_r  <= 32'h00000000;
      end else begin
         wr_pend_r <= addr_ok & hwrite_i;
         if (addr_ok)
            wr_addr_r <= haddr_i;
         if (addr_ok & ~hwrite_i) begin
            if (haddr_i == `ROSL_CFG_CTRL_OFS)
               hrdata_r <= cfg_ctrl;
            else if (haddr_i == `ROSL_STATUS_OFS)
               hrdata_r <= {29'h0, key_state_r == KEY_ARMED, lock_seen_r, once_opt_r};
            else if (rd_out_idx != 4'hf)
               hrdata_r <= {28'h0, out_sel_r[rd_out_idx[2:0]]};
            else if (rd_in_idx != 4'hf)
               hrdata_r <= {28'h0, in_sel_r[rd_in_idx[2:0]]};
            else
               hrdata_r <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------
   // Unlock sequence and lock bit
   // ----------------------------------------
   // Key one then key two arms one lock change; any other write disarms
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         key_state_r      <= KEY_IDLE;
         map_write_lock_r <= 1'b0;
         lock_seen_r      <= 1'b0;
      end else if (wr_pend_r) begin
         case (key_state_r)
            KEY_IDLE: begin
               if (wr_addr_r == `ROSL_UNLOCK_KEY_OFS && hwdata_i == `ROSL_KEY1)
                  key_state_r <= KEY_HALF;
            end
            KEY_HALF: begin
               if (wr_addr_r == `ROSL_UNLOCK_KEY_OFS && hwdata_i == `ROSL_KEY2)
                  key_state_r <= KEY_ARMED;
               else
                  key_state_r <= KEY_IDLE;
            end
            KEY_ARMED: begin
               key_state_r <= KEY_IDLE;
               if (wr_addr_r == `ROSL_CFG_CTRL_OFS) begin
                  // Once set with the option on, clearing is refused until reset
                  if (!(once_opt_r && lock_seen_r && map_write_lock_r)) begin
                     map_write_lock_r <= hwdata_i[`ROSL_LOCK_BIT];
                     if (hwdata_i[`ROSL_LOCK_BIT])
                        lock_seen_r <= 1'b1;
                  end
               end
            end
            default: key_state_r <= KEY_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Mapping registers
   // ----------------------------------------
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (i = 0; i < 8; i = i + 1) begin
            out_sel_r[i] <= `ROSL_SEL_NULL;
            in_sel_r[i]  <= `ROSL_SEL_NULL;
         end
      end else if (wr_pend_r && !map_write_lock_r) begin
         if (wr_out_idx != 4'hf)
            out_sel_r[wr_out_idx[2:0]] <= hwdata_i[3:0];
         else if (wr_in_idx != 4'hf)
            in_sel_r[wr_in_idx[2:0]] <= hwdata_i[3:0];
      end
   end

   // ----------------------------------------
   // Input synchroniser and input routing
   // ----------------------------------------
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_in_s1_r <= 8'h00;
         pin_in_s2_r <= 8'h00;
      end else begin
         pin_in_s1_r <= pin_in_i;
         pin_in_s2_r <= pin_in_s1_r;
      end
   end

   // Input code 0 or above 8 means no pin; code n from 1 to 8 picks pin n-1
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_map
         assign periph_in_o[g] = (in_sel_r[g] != `ROSL_SEL_NULL && in_sel_r[g] < 4'h9) ?
                                 pin_in_s2_r[in_sel_r[g][2:0] - 3'h1] : 1'b0;
         rosl_out_mux u_mux (
            .sel_i        (out_sel_r[g]),
            .periph_out_i (periph_out_i),
            .pin_o        (pin_o[g]),
            .pin_oe_o     (pin_oe_o[g])
         );
      end
   endgenerate

endmodule // rosl_pin_map

// *** logic/rosl_regs.vh ***
// Purpose : Register map and field constants for the remappable output select block
// Assumes : 32-bit AHB-Lite slave, word-aligned registers
// Notes   : Definitions only
`ifndef ROSL_REGS_VH
`define ROSL_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ROSL_CFG_CTRL_OFS    12'h000
`define ROSL_UNLOCK_KEY_OFS  12'h004
`define ROSL_STATUS_OFS      12'h008
`define ROSL_IN_SEL_BASE     12'h100
`define ROSL_OUT_SEL_BASE    12'h200

// ----------------------------------------
// Fields and values
// ----------------------------------------
`define ROSL_LOCK_BIT        13
`define ROSL_CFG3_ONCE_BIT   29
`define ROSL_SEL_W           4
`define ROSL_SEL_NULL        4'h0
`define ROSL_NUM_PINS        8
`define ROSL_NUM_PERIPH      15
`define ROSL_NUM_IN          8
`define ROSL_KEY1            32'haa996655
`define ROSL_KEY2            32'h556699aa
`define ROSL_CFG3_RESET      32'hffffffff

`endif

// *** testbench/remappable_output_select_lock_tb.sv ***
// Purpose: Self-checking bench for rosl_pin_map
// Assumes: Zero wait AHB-Lite slave, 100 MHz clock
// Notes: Far side comes from rosl_far_model
`timescale 1ns/1ps
`include "rosl_regs.vh"
module remappable_output_select_lock_tb;
   reg         clk = 0, rst_n = 0, hw = 0;
   reg  [1:0]  ht = 0;
   reg  [11:0] ha = 0;
   reg  [31:0] hd = 0, cfg3 = `ROSL_CFG3_RESET, q;
   wire [31:0] hrdata;
   wire        hrdyo, lock;
   wire [14:0] periph;
   wire [7:0]  pin, oe, pin_in, pin_sel_in;
   reg  [7:0]  syn1 = 0, syn2 = 0;
   integer     failures = 0, checks_done = 0, cyc = 0;
   rosl_far_model rosl_far_model_i (.core_clk_i(clk), .periph_out_o(periph), .pin_in_o(pin_in));
   rosl_pin_map rosl_pin_map_i (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(ha),
      .htrans_i(ht), .hwrite_i(hw), .hsize_i(3'h2), .hready_i(hrdyo), .hwdata_i(hd),
      .hrdata_o(hrdata), .hreadyout_o(hrdyo), .hresp_o(), .device_config_word_three_i(cfg3),
      .periph_out_i(periph), .pin_o(pin), .pin_oe_o(oe), .pin_in_i(pin_in),
      .periph_in_o(pin_sel_in),
      .map_write_lock_o(lock));
   initial forever #5 clk = ~clk;
   // Pins reach input routing through two flops
   always @(posedge clk) begin
      syn1 <= pin_in;
      syn2 <= syn1;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin failures = failures + 1; stop_test; end
   end
   task stop_test; begin
      $display("failures=%0d checks_done=%0d", failures, checks_done);
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   end endtask
   task chk(input [31:0] g, input [31:0] e); begin
      checks_done = checks_done + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   end endtask
   // Address phase held until hready; read data taken at the closing edge
   task ahb(input w, input [11:0] a, input [31:0] d); begin
      @(posedge clk); ha <= a; hw <= w; ht <= 2'b10;
      do @(posedge clk); while (!hrdyo);
      ht <= 2'b00; hd <= d;
      do @(posedge clk); while (!hrdyo);
      q = hrdata;
   end endtask
   task wrp(input [11:0] a, input [31:0] d, input [7:0] e); begin
      ahb(1'b1, a, d); @(negedge clk); chk(oe, e);
   end endtask
   // Both keys, then the control write that carries the new lock
   task ul(input [31:0] v, input e); begin
      ahb(1'b1, 12'h004, `ROSL_KEY1); ahb(1'b1, 12'h004, `ROSL_KEY2);
      ahb(1'b1, 12'h000, v); #1 chk(lock, e);
   end endtask
   task rdc(input [11:0] a, input [31:0] e); begin
      ahb(1'b0, a, 32'h0); chk(q, e);
   end endtask
   task t_route; begin
      chk(oe, 8'h00);
      wrp(12'h208, 32'h5, 8'h04); chk(pin[2], periph[4]);
      wrp(12'h21c, 32'hf, 8'h84); chk(pin[7], periph[14]);
      wrp(12'h208, 32'h0, 8'h80);
      ahb(1'b1, 12'h104, 32'h3); rdc(12'h104, 32'h3);
      @(negedge clk); chk(pin_sel_in[1], syn2[2]);
   end endtask
   task t_lock; begin
      ahb(1'b1, 12'h000, 32'h2000); #1 chk(lock, 1'b0);
      ahb(1'b1, 12'h004, `ROSL_KEY1); ahb(1'b1, 12'h000, 32'h2000); #1 chk(lock, 1'b0);
      ul(32'h2000, 1'b1); rdc(12'h000, 32'h2000);
      wrp(12'h21c, 32'h1, 8'h80);
      ahb(1'b1, 12'h104, 32'h6); rdc(12'h104, 32'h3);
      ahb(1'b0, 12'h008, 32'h0); chk(q[0], 1'b1);
      ul(32'h0, 1'b1);
   end endtask
   task t_rearm; begin
      @(posedge clk); rst_n <= 1'b0; cfg3 <= 32'h0;
      @(negedge clk); chk(oe, 8'h00); chk(lock, 1'b0);
      @(posedge clk); rst_n <= 1'b1;
      rdc(12'h104, 32'h0); rdc(12'h21c, 32'h0);
      ul(32'h2000, 1'b1); ul(32'h0, 1'b0);
      wrp(12'h208, 32'h9, 8'h04);
   end endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_route; $display("t_route end");
      t_lock; $display("t_lock end");
      t_rearm; $display("t_rearm end");
      stop_test;
   end
endmodule // remappable_output_select_lock_tb

// *** testbench/rosl_far_model.sv ***
// Purpose: Far side model of peripheral outputs and device pins
// Assumes: Free-running logic on the core clock
// Notes: Pattern moves every cycle so stale routing shows
`timescale 1ns/1ps
module rosl_far_model (
   input  wire        core_clk_i,
   output reg  [14:0] periph_out_o = 15'h1234,
   output wire [7:0]  pin_in_o
);
   always @(posedge core_clk_i) periph_out_o <= {periph_out_o[13:0], ~periph_out_o[14]};
   assign pin_in_o = periph_out_o[7:0] ^ 8'h5a;
endmodule // rosl_far_model

// *** testbench/rosl_pm_checker.sv ***
// Purpose: Port assertions for rosl_pin_map
// Assumes: One clock, always-ready slave
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
module rosl_pm_checker (
   input wire        core_clk_i,
   input wire        rst_n_i,
   input wire        hsel_i,
   input wire [11:0] haddr_i,
   input wire [1:0]  htrans_i,
   input wire        hwrite_i,
   input wire        hready_i,
   input wire [31:0] hrdata_o,
   input wire        hreadyout_o,
   input wire        hresp_o,
   input wire [31:0] device_config_word_three_i,
   input wire [7:0]  pin_o,
   input wire [7:0]  pin_oe_o,
   input wire        map_write_lock_o
);
   reg        rd_r;
   reg        cw_r;
   reg [11:0] ad_r;
   // Data-phase record, so a check knows which register a transfer hit
   always @(posedge core_clk_i) begin
      rd_r <= hsel_i & hready_i & htrans_i[1] & !hwrite_i;
      cw_r <= hsel_i & hready_i & htrans_i[1] & hwrite_i & (haddr_i == 12'h000);
      ad_r <= haddr_i;
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence cfg_rd_s; rd_r && ad_r == 12'h000; endsequence
   sequence stat_rd_s; rd_r && ad_r == 12'h008; endsequence
   ok_resp_a: assert property (hreadyout_o && !hresp_o) else $error("bad resp");
   null_pin_a: assert property ((pin_o & ~pin_oe_o) == 8'h00) else $error("pin high");
   lock_cause_a: assert property ($changed(map_write_lock_o) |-> $past(cw_r))
      else $error("lock moved alone");
   no_clear_a: assert property ($fell(map_write_lock_o) |-> !device_config_word_three_i[29])
      else $error("lock cleared");
   lock_hold_a: assert property ($past(map_write_lock_o) |-> $stable(pin_oe_o))
      else $error("remap while locked");
   cfg_read_a: assert property (cfg_rd_s |-> hrdata_o[13] == map_write_lock_o)
      else $error("lock readback");
   status_read_a: assert property (stat_rd_s |-> hrdata_o[0] == device_config_word_three_i[29])
      else $error("option readback");
   reset_clear_a:
      assert property (disable iff (1'b0) !rst_n_i [*2] |-> pin_oe_o == 8'h00 && !map_write_lock_o)
      else $error("reset state");
endmodule // rosl_pm_checker
bind rosl_pin_map rosl_pm_checker rosl_pm_checker_i (.*);
